// ---- inc/pdsp_pkg.sv ----
// constants and carrier types for the protocol debug strobe port
// assumes event inputs are one-cycle pulses from the protocol engine, synchronous to i_mclk
package pdsp_pkg;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned N_FUNC = 14;
    localparam int unsigned STRETCH_CYCLES = 3;
    localparam int unsigned STATIC_CYCLES = 1;
    localparam int unsigned CNT_W = 2;
    localparam int unsigned VALID_DELAY_BITS = 11;
    localparam int unsigned BITCNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
    localparam logic [BITCNT_W-1:0] BITCNT_RESET = 4'h0;

    typedef enum logic [SEL_W-1:0] {
        F_STATE_CHANGE = 4'h0,
        F_STATIC_SLOT = 4'h1,
        F_MINISLOT = 4'h2,
        F_RX_A = 4'h3,
        F_DYN_SLOT_A = 4'h4,
        F_FRAME_START_A = 4'h5,
        F_VALID_FRAME_A = 4'h6,
        F_CYCLE_START = 4'h7,
        F_MACROTICK = 4'h8,
        F_OFFSET_CORR = 4'h9,
        F_RX_B = 4'ha,
        F_DYN_SLOT_B = 4'hb,
        F_FRAME_START_B = 4'hc,
        F_VALID_FRAME_B = 4'hd
    } pdsp_func_e;

    // per-channel event pulses from the protocol engine
    typedef struct packed {
        logic rx_filt;
        logic dyn_slot;
        logic frame_start;
        logic frame_end;
        logic frame_valid;
    } pdsp_chan_s;

    // channel independent events
    typedef struct packed {
        logic state_change;
        logic static_slot;
        logic minislot;
        logic cycle_start;
        logic nit_start;
        logic macrotick;
        logic offset_corr;
        logic bit_tick;
    } pdsp_evt_s;
endpackage : pdsp_pkg

// ---- logic/pdsp_top.sv ----
// protocol debug strobe port: maps protocol engine events onto two debug pins
// assumes events are single-cycle pulses in the i_mclk domain; bit_tick marks each bus bit
`timescale 1ns/1ns
module pdsp_top (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire pdsp_pkg::pdsp_evt_s i_evt,
    input wire pdsp_pkg::pdsp_chan_s i_chan_a,
    input wire pdsp_pkg::pdsp_chan_s i_chan_b,
    input wire logic [pdsp_pkg::SEL_W-1:0] i_sel_1,
    input wire logic [pdsp_pkg::SEL_W-1:0] i_sel_2,
    output logic o_debug_out_1,
    output logic o_debug_out_2
);
    // stretch counters for the three-clock functions except macrotick, one per source
    logic [pdsp_pkg::CNT_W-1:0] st_cnt_q [8];
    logic [pdsp_pkg::CNT_W-1:0] st_cnt_d [8];
    logic [7:0] st_trig;
    logic static_q, static_d;
    logic cycle_q, cycle_d;
    logic offs_q, offs_d;
    // valid frame delay: armed at frame end, counts bus bits
    logic [1:0] vf_arm_q, vf_arm_d;
    logic [pdsp_pkg::BITCNT_W-1:0] vf_cnt_q [2];
    logic [pdsp_pkg::BITCNT_W-1:0] vf_cnt_d [2];
    logic [1:0] vf_fire;
    logic [pdsp_pkg::N_FUNC-1:0] func;
    logic debug_out_1_q, debug_out_1_d, debug_out_2_q, debug_out_2_d;
    pdsp_pkg::pdsp_chan_s ch [2];

    assign ch[0] = i_chan_a;
    assign ch[1] = i_chan_b;

    always_comb begin
        vf_arm_d = vf_arm_q;
        vf_fire = 2'h0;
        for (int c = 0; c < 2; c++) begin
            vf_cnt_d[c] = vf_cnt_q[c];
            if (ch[c].frame_end && ch[c].frame_valid) begin
                vf_arm_d[c] = 1'b1;
                vf_cnt_d[c] = pdsp_pkg::BITCNT_RESET;
            end else if (vf_arm_q[c] && i_evt.bit_tick) begin
                if (vf_cnt_q[c] == pdsp_pkg::BITCNT_W'(pdsp_pkg::VALID_DELAY_BITS - 1)) begin
                    vf_fire[c] = 1'b1;
                    vf_arm_d[c] = 1'b0;
                    vf_cnt_d[c] = pdsp_pkg::BITCNT_RESET;
                end else begin
                    vf_cnt_d[c] = vf_cnt_q[c] + 1'b1;
                end
            end
        end
    end

    always_comb begin
        st_trig = {vf_fire[1], vf_fire[0], i_chan_b.frame_start, i_chan_a.frame_start,
                   i_chan_b.dyn_slot, i_chan_a.dyn_slot, i_evt.minislot, i_evt.state_change};
        for (int k = 0; k < 8; k++) begin
            if (st_trig[k]) begin
                st_cnt_d[k] = pdsp_pkg::CNT_W'(pdsp_pkg::STRETCH_CYCLES);
            end else if (st_cnt_q[k] != pdsp_pkg::CNT_RESET) begin
                st_cnt_d[k] = st_cnt_q[k] - 1'b1;
            end else begin
                st_cnt_d[k] = pdsp_pkg::CNT_RESET;
            end
        end
        static_d = i_evt.static_slot;
        offs_d = i_evt.offset_corr;
        if (i_evt.cycle_start) begin
            cycle_d = 1'b1;
        end else if (i_evt.nit_start) begin
            cycle_d = 1'b0;
        end else begin
            cycle_d = cycle_q;
        end
    end

    // macrotick stretch: the pulse is three clocks wide, shorter than a macrotick
    logic [pdsp_pkg::CNT_W-1:0] mt_cnt_q, mt_cnt_d;
    always_comb begin
        if (i_evt.macrotick) begin
            mt_cnt_d = pdsp_pkg::CNT_W'(pdsp_pkg::STRETCH_CYCLES);
        end else if (mt_cnt_q != pdsp_pkg::CNT_RESET) begin
            mt_cnt_d = mt_cnt_q - 1'b1;
        end else begin
            mt_cnt_d = pdsp_pkg::CNT_RESET;
        end
    end

    always_comb begin
        func = '0;
        func[pdsp_pkg::F_STATE_CHANGE] = st_cnt_q[0] != pdsp_pkg::CNT_RESET;
        func[pdsp_pkg::F_STATIC_SLOT] = static_q;
        func[pdsp_pkg::F_MINISLOT] = st_cnt_q[1] != pdsp_pkg::CNT_RESET;
        func[pdsp_pkg::F_RX_A] = i_chan_a.rx_filt;
        func[pdsp_pkg::F_DYN_SLOT_A] = st_cnt_q[2] != pdsp_pkg::CNT_RESET;
        func[pdsp_pkg::F_FRAME_START_A] = st_cnt_q[4] != pdsp_pkg::CNT_RESET;
        func[pdsp_pkg::F_VALID_FRAME_A] = st_cnt_q[6] != pdsp_pkg::CNT_RESET;
        func[pdsp_pkg::F_CYCLE_START] = cycle_q;
        func[pdsp_pkg::F_MACROTICK] = mt_cnt_q != pdsp_pkg::CNT_RESET;
        func[pdsp_pkg::F_OFFSET_CORR] = offs_q;
        func[pdsp_pkg::F_RX_B] = i_chan_b.rx_filt;
        func[pdsp_pkg::F_DYN_SLOT_B] = st_cnt_q[3] != pdsp_pkg::CNT_RESET;
        func[pdsp_pkg::F_FRAME_START_B] = st_cnt_q[5] != pdsp_pkg::CNT_RESET;
        func[pdsp_pkg::F_VALID_FRAME_B] = st_cnt_q[7] != pdsp_pkg::CNT_RESET;
        // unused select codes drive low
        debug_out_1_d = (i_sel_1 < pdsp_pkg::SEL_W'(pdsp_pkg::N_FUNC)) ? func[i_sel_1] : 1'b0;
        debug_out_2_d = (i_sel_2 < pdsp_pkg::SEL_W'(pdsp_pkg::N_FUNC)) ? func[i_sel_2] : 1'b0;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int k = 0; k < 8; k++) begin
                st_cnt_q[k] <= pdsp_pkg::CNT_RESET;
            end
            for (int c = 0; c < 2; c++) begin
                vf_cnt_q[c] <= pdsp_pkg::BITCNT_RESET;
            end
            vf_arm_q <= 2'h0;
            mt_cnt_q <= pdsp_pkg::CNT_RESET;
            static_q <= 1'b0;
            cycle_q <= 1'b0;
            offs_q <= 1'b0;
            debug_out_1_q <= 1'b0;
            debug_out_2_q <= 1'b0;
        end else if (i_ce) begin
            for (int k = 0; k < 8; k++) begin
                st_cnt_q[k] <= st_cnt_d[k];
            end
            for (int c = 0; c < 2; c++) begin
                vf_cnt_q[c] <= vf_cnt_d[c];
            end
            vf_arm_q <= vf_arm_d;
            mt_cnt_q <= mt_cnt_d;
            static_q <= static_d;
            cycle_q <= cycle_d;
            offs_q <= offs_d;
            debug_out_1_q <= debug_out_1_d;
            debug_out_2_q <= debug_out_2_d;
        end
    end

    assign o_debug_out_1 = debug_out_1_q;
    assign o_debug_out_2 = debug_out_2_q;
endmodule : pdsp_top

// ---- tb/pdsp_checker.sv ----
// assertions on the two debug pins
// assumes the ports of pdsp_top, one clock domain
`timescale 1ns/1ns
module pdsp_checker (
    input logic i_mclk,
    input logic i_rstn,
    input logic i_ce,
    input pdsp_pkg::pdsp_evt_s i_evt,
    input pdsp_pkg::pdsp_chan_s i_chan_a,
    input pdsp_pkg::pdsp_chan_s i_chan_b,
    input logic [pdsp_pkg::SEL_W-1:0] i_sel_1,
    input logic [pdsp_pkg::SEL_W-1:0] i_sel_2,
    input logic o_debug_out_1,
    input logic o_debug_out_2
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // events reach the pin two edges after they are sampled
    sequence ss1;
        i_ce && i_sel_1 == 4'h1 && i_evt.static_slot ##1 i_ce && i_sel_1 == 4'h1 && !i_evt.static_slot
            ##1 i_ce && i_sel_1 == 4'h1;
    endsequence
    sequence oc2;
        i_ce && i_sel_2 == 4'h9 && i_evt.offset_corr ##1 i_ce && i_sel_2 == 4'h9 && !i_evt.offset_corr
            ##1 i_ce && i_sel_2 == 4'h9;
    endsequence
    AST_SC: assert property (i_ce && i_sel_1 == 4'h0 && i_evt.state_change ##1 i_ce && i_sel_1 == 4'h0 |=> o_debug_out_1 [*3])
        else $error("short pulse");
    AST_SS: assert property (ss1 |-> o_debug_out_1 ##1 !o_debug_out_1)
        else $error("static width");
    AST_OC: assert property (oc2 |-> o_debug_out_2 ##1 !o_debug_out_2)
        else $error("offset width");
    AST_MT: assert property (i_ce && i_sel_2 == 4'h8 && i_evt.macrotick ##1 i_ce && i_sel_2 == 4'h8 |=> o_debug_out_2 [*3])
        else $error("macrotick");
    AST_CSH: assert property (i_ce && i_sel_1 == 4'h7 && i_evt.cycle_start ##1 i_ce && i_sel_1 == 4'h7 |=> o_debug_out_1)
        else $error("cycle rise");
    AST_CSL: assert property (i_ce && i_sel_1 == 4'h7 && i_evt.nit_start && !i_evt.cycle_start ##1 i_ce && i_sel_1 == 4'h7 |=> !o_debug_out_1)
        else $error("cycle fall");
    AST_RX: assert property (i_ce && i_sel_1 == 4'h3 |=> o_debug_out_1 == $past(i_chan_a.rx_filt))
        else $error("rx");
    AST_LOW: assert property ((i_ce && i_sel_1 == 4'h0 && !i_evt.state_change) [*4] |=> !o_debug_out_1)
        else $error("idle");
endmodule : pdsp_checker
bind pdsp_top pdsp_checker pdsp_checker_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_evt(i_evt),
    .i_chan_a(i_chan_a), .i_chan_b(i_chan_b), .i_sel_1(i_sel_1), .i_sel_2(i_sel_2),
    .o_debug_out_1(o_debug_out_1), .o_debug_out_2(o_debug_out_2));

// ---- tb/pdsp_probe.sv ----
// probe on the debug pins: counts rising edges
// assumes pins are sampled on the controller clock
`timescale 1ns/1ns
module pdsp_probe (
    input logic i_mclk,
    input logic i_pin_1,
    input logic i_pin_2,
    output int o_rise_1,
    output int o_rise_2
);
    logic p1_q = 1'b0;
    logic p2_q = 1'b0;
    initial o_rise_1 = 0;
    initial o_rise_2 = 0;
    always @(posedge i_mclk) begin
        o_rise_1 <= o_rise_1 + int'(i_pin_1 && !p1_q);
        o_rise_2 <= o_rise_2 + int'(i_pin_2 && !p2_q);
        p1_q <= i_pin_1;
        p2_q <= i_pin_2;
    end
endmodule : pdsp_probe

// ---- tb/pdsp_top_test.sv ----
// self-checking bench for the debug strobe port
// assumes pdsp_top, the probe model and the bound checker
`timescale 1ns/1ns
module pdsp_top_test;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_ce = 1'b1;
    pdsp_pkg::pdsp_evt_s evt = '0;
    pdsp_pkg::pdsp_chan_s cha = '0;
    pdsp_pkg::pdsp_chan_s chb = '0;
    logic [3:0] s1 = 4'hf;
    logic [3:0] s2 = 4'hf;
    logic o1;
    logic o2;
    int r1;
    int errors = 0;
    int compares = 0;
    `define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
    always #2 i_mclk = ~i_mclk;
    pdsp_top pdsp_top_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_evt(evt), .i_chan_a(cha),
        .i_chan_b(chb), .i_sel_1(s1), .i_sel_2(s2), .o_debug_out_1(o1), .o_debug_out_2(o2));
    pdsp_probe pdsp_probe_inst (.i_mclk(i_mclk), .i_pin_1(o1), .i_pin_2(o2), .o_rise_1(r1), .o_rise_2());
    task automatic strobe(input logic [3:0] c, input int n, input logic [17:0] v);
        s1 = c;
        s2 = c;
        @(negedge i_mclk);
        {evt, cha, chb} = v;
        @(negedge i_mclk);
        {evt, cha, chb} = '0;
        @(negedge i_mclk);
        repeat (n) begin
            `CHK({o1, o2}, 2'h3)
            @(negedge i_mclk);
        end
        `CHK({o1, o2}, 2'h0)
    endtask : strobe
    task automatic t_merge();
        int k;
        k = r1;
        s1 = 4'h2;
        evt = 8'h20;
        repeat (2) @(negedge i_mclk);
        evt = '0;
        repeat (5) @(negedge i_mclk);
        `CHK(r1 - k, 1)
    endtask : t_merge
    task automatic t_valid(input logic [3:0] c, input logic [9:0] ab);
        s1 = c;
        s2 = c;
        {evt, cha, chb} = {8'h00, ab};
        for (int k = 1; k <= 11; k++) begin
            @(negedge i_mclk);
            {evt, cha, chb} = {8'h01, 10'h000};
            @(negedge i_mclk);
            evt = '0;
            `CHK({o1, o2}, 2'h0)
        end
        @(negedge i_mclk);
        `CHK({o1, o2}, 2'h3)
        repeat (3) @(negedge i_mclk);
    endtask : t_valid
    task automatic t_cycle();
        s1 = 4'h7;
        evt = 8'h10;
        @(negedge i_mclk);
        evt = '0;
        @(negedge i_mclk);
        `CHK(o1, 1'b1)
        i_ce = 1'b0;
        evt = 8'h08;
        repeat (6) @(negedge i_mclk);
        `CHK(o1, 1'b1)
        i_ce = 1'b1;
        @(negedge i_mclk);
        evt = '0;
        @(negedge i_mclk);
        `CHK(o1, 1'b0)
    endtask : t_cycle
    task automatic t_rx();
        s1 = 4'h3;
        s2 = 4'ha;
        for (int k = 0; k < 4; k++) begin
            {cha, chb} = {k[0], 4'h0, ~k[0], 4'h0};
            @(negedge i_mclk);
            `CHK({o1, o2}, {k[0], ~k[0]})
        end
    endtask : t_rx
    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (2) @(negedge i_mclk);
        i_rstn = 1'b1;
        `CHK({o1, o2}, 2'h0)
        strobe(4'h0, 3, 18'h20000);
        strobe(4'h1, 1, 18'h10000);
        strobe(4'h2, 3, 18'h08000);
        strobe(4'h4, 3, 18'h00100);
        strobe(4'h5, 3, 18'h00080);
        strobe(4'h8, 3, 18'h01000);
        strobe(4'h9, 1, 18'h00800);
        strobe(4'hb, 3, 18'h00008);
        strobe(4'hc, 3, 18'h00004);
        t_merge();
        t_valid(4'h6, 10'h060);
        t_valid(4'hd, 10'h003);
        t_cycle();
        t_rx();
        test_done();
    end
endmodule : pdsp_top_test
